//--- src/tbn_handler.v
// Card-side Type B network command handler
// Frames arrive as bytes with CRC already checked and stripped; the
// response stream is sent without SOF, CRC or EOF, which the framer adds.
`default_nettype none
`include "tbn_defs.vh"
module tbn_handler (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Received frame bytes, CRC stripped
    input  wire        rx_valid_i,
    input  wire [7:0]  rx_data_i,
    input  wire        rx_sof_i,
    input  wire        rx_eof_i,
    // Card identity and configuration
    input  wire [63:0] uid_i,
    input  wire [31:0] app_data_i,
    input  wire [7:0]  afi_i,
    // Response byte stream
    output reg         tx_valid_o,
    output reg  [7:0]  tx_data_o,
    output reg         tx_last_o,
    input  wire        tx_ready_i,
    // Status
    output reg  [2:0]  state_o,
    output reg  [3:0]  cid_o,
    output reg  [3:0]  slot_o,
    output reg         active_o
);
    // ------------------------------------------------------------
    // Frame capture
    // ------------------------------------------------------------
    reg  [2:0]  state;
    reg  [3:0]  cid;
    reg  [3:0]  slot;
    reg  [7:0]  b0;
    reg  [7:0]  b1;
    reg  [7:0]  b2;
    reg  [7:0]  b5;
    reg  [31:0] pupi_rx;
    reg  [3:0]  nbytes;
    reg  [15:0] lfsr;
    reg         frame_done;

    always @(posedge clk_i) begin
        if (rst_i) begin
            b0         <= 8'h00;
            b1         <= 8'h00;
            b2         <= 8'h00;
            b5         <= 8'h00;
            pupi_rx    <= 32'h00000000;
            nbytes     <= 4'h0;
            frame_done <= 1'b0;
        end else begin
            frame_done <= 1'b0;
            if (rx_sof_i)
                nbytes <= 4'h0;
            if (rx_valid_i) begin
                // Payload between start of frame and CRC
                case (rx_sof_i ? 4'h0 : nbytes)
                4'h0: b0 <= rx_data_i;
                4'h1: begin
                    b1      <= rx_data_i;
                    pupi_rx <= {24'h000000, rx_data_i};
                end
                4'h2: begin
                    b2      <= rx_data_i;
                    pupi_rx[15:8] <= rx_data_i;
                end
                4'h3: pupi_rx[23:16] <= rx_data_i;
                4'h4: pupi_rx[31:24] <= rx_data_i;
                4'h8: b5 <= rx_data_i;
                default: b5 <= b5;
                endcase
                if (nbytes != 4'hf)
                    nbytes <= (rx_sof_i ? 4'h0 : nbytes) + 4'h1;
            end
            if (rx_eof_i)
                frame_done <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire       is_req   = (b0 == `TBN_CMD_REQ);
    wire       is_wup   = b2[`TBN_PAR_WUP];
    wire       afi_ok   = (b1 == `TBN_AFI_ANY) ||
                          ((b1[3:0] == `TBN_NIB_ZERO) &&
                           (b1[7:4] == afi_i[7:4])) ||
                          (b1 == afi_i);
    wire       code_ok  = (b2[2:0] <= `TBN_CODE_MAX);
    wire       is_sm    = (b0[3:0] == `TBN_SM_NIB) &&
                          (b0[7:4] != `TBN_NIB_ZERO);
    wire       is_att   = (b0 == `TBN_CMD_ATTRIB);
    wire       is_des   = (b0 == `TBN_CMD_DESEL);
    wire       pupi_ok  = (pupi_rx == uid_i[31:0]);
    wire [3:0] nmask;
    reg  [3:0] draw;

    // Slot count minus one as a mask: 1,2,4,8,16 slots
    assign nmask = (b2[2:0] == 3'h0) ? 4'h0 :
                   (b2[2:0] == 3'h1) ? 4'h1 :
                   (b2[2:0] == 3'h2) ? 4'h3 :
                   (b2[2:0] == 3'h3) ? 4'h7 : 4'hf;

    always @* begin
        draw = lfsr[3:0] & nmask;
    end

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    reg        send_atqb;
    reg        send_ack;
    reg        send_att;
    reg  [2:0] next_state;
    reg  [3:0] next_slot;
    reg  [3:0] next_cid;
    reg        req_take;

    always @* begin
        next_state = state;
        next_slot  = slot;
        next_cid   = cid;
        send_atqb  = 1'b0;
        send_att   = 1'b0;
        send_ack   = 1'b0;
        req_take   = 1'b0;
        if (frame_done) begin
            if (is_req && (nbytes == `TBN_LEN_REQ) && code_ok) begin
                case (state)
                `TBN_ST_IDLE, `TBN_ST_WAIT, `TBN_ST_READY:
                    req_take = 1'b1;
                `TBN_ST_HALT:
                    req_take = is_wup;
                default:
                    req_take = 1'b0;
                endcase
            end
            if (req_take) begin
                if (!afi_ok) begin
                    next_state = `TBN_ST_IDLE;
                end else if (nmask == 4'h0 || draw == 4'h0) begin
                    // Slot value zero here stands for slot one
                    next_state = `TBN_ST_READY;
                    next_slot  = 4'h0;
                    send_atqb  = 1'b1;
                end else begin
                    next_state = `TBN_ST_WAIT;
                    next_slot  = draw;
                end
            end else if (state == `TBN_ST_WAIT && is_sm &&
                         nbytes == `TBN_LEN_SM) begin
                // Any slot order accepted
                if (b0[7:4] == slot) begin
                    next_state = `TBN_ST_READY;
                    send_atqb  = 1'b1;
                end
            end else if (state == `TBN_ST_READY && is_att &&
                         nbytes >= `TBN_LEN_ATT && pupi_ok) begin
                next_state = `TBN_ST_ACTIVE;
                next_cid   = b5[3:0];
                send_att   = 1'b1;
            end else if (state == `TBN_ST_ACTIVE && is_des) begin
                next_state = `TBN_ST_HALT;
                send_ack   = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Response sequencer into the buffer
    // ------------------------------------------------------------
    reg  [3:0] tx_idx;
    reg  [3:0] tx_len;
    reg        tx_busy;
    reg        tx_kind;
    reg  [7:0] tx_byte;
    wire       buf_ready;
    wire       buf_valid;
    wire [7:0] buf_data;
    wire       push = tx_busy & buf_ready;

    always @* begin
        case (tx_idx)
        4'h0: tx_byte = tx_kind ? {4'h0, cid} : `TBN_ATQB_IND;
        4'h1: tx_byte = uid_i[7:0];
        4'h2: tx_byte = uid_i[15:8];
        4'h3: tx_byte = uid_i[23:16];
        4'h4: tx_byte = uid_i[31:24];
        4'h5: tx_byte = app_data_i[7:0];
        4'h6: tx_byte = app_data_i[15:8];
        4'h7: tx_byte = app_data_i[23:16];
        4'h8: tx_byte = app_data_i[31:24];
        4'h9: tx_byte = `TBN_PI_BYTE0;
        4'ha: tx_byte = `TBN_PI_BYTE1;
        4'hb: tx_byte = {`TBN_FWI, `TBN_ADC, `TBN_FO};
        default: tx_byte = 8'h00;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state   <= `TBN_ST_IDLE;
            cid     <= 4'h0;
            slot    <= 4'h0;
            lfsr    <= `TBN_LFSR_SEED;
            tx_idx  <= 4'h0;
            tx_len  <= 4'h0;
            tx_busy <= 1'b0;
            tx_kind <= 1'b0;
        end else begin
            state <= next_state;
            cid   <= next_cid;
            slot  <= next_slot;
            lfsr  <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            if (send_atqb) begin
                tx_busy <= 1'b1;
                tx_idx  <= 4'h0;
                tx_len  <= `TBN_ATQB_LEN;
                tx_kind <= 1'b0;
            end else if (send_att || send_ack) begin
                tx_busy <= 1'b1;
                tx_idx  <= 4'h0;
                tx_len  <= 4'h1;
                tx_kind <= send_att;
            end else if (push) begin
                tx_idx <= tx_idx + 4'h1;
                if (tx_idx + 4'h1 == tx_len)
                    tx_busy <= 1'b0;
            end
        end
    end

    // Byte and last-flag travel together through the buffer
    wire [8:0] push_word = {(tx_idx + 4'h1 == tx_len),
                            (tx_len == 4'h1 && !tx_kind) ?
                            `TBN_ATTRIB_OK : tx_byte};
    wire [8:0] pop_word;
    wire       out_take = buf_valid & (~tx_valid_o | tx_ready_i);

    tbn_buf #(
        .W(9)
    ) u_buf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (tx_busy),
        .in_ready_o  (buf_ready),
        .in_data_i   (push_word),
        .out_valid_o (buf_valid),
        .out_ready_i (~tx_valid_o | tx_ready_i),
        .out_data_o  (pop_word)
    );
    assign buf_data = pop_word[7:0];

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_valid_o <= 1'b0;
            tx_data_o  <= 8'h00;
            tx_last_o  <= 1'b0;
            state_o    <= `TBN_ST_IDLE;
            cid_o      <= 4'h0;
            slot_o     <= 4'h0;
            active_o   <= 1'b0;
        end else begin
            if (out_take) begin
                tx_valid_o <= 1'b1;
                tx_data_o  <= buf_data;
                tx_last_o  <= pop_word[8];
            end else if (tx_ready_i) begin
                tx_valid_o <= 1'b0;
            end
            state_o  <= state;
            cid_o    <= cid;
            slot_o   <= slot;
            active_o <= (state == `TBN_ST_ACTIVE);
        end
    end
endmodule
`default_nettype wire

//--- src/tbn_defs.vh
// Constants for the Type B network command handler
`ifndef TBN_DEFS_VH
`define TBN_DEFS_VH
`define TBN_CMD_REQ      8'h05
`define TBN_CMD_ATTRIB   8'h1d
`define TBN_CMD_DESEL    8'hc2
`define TBN_SM_NIB       4'h5
`define TBN_ATQB_IND     8'h50
`define TBN_ATTRIB_OK    8'h00
`define TBN_AFI_ANY      8'h00
`define TBN_NIB_ZERO     4'h0
`define TBN_PI_BYTE0     8'h77
`define TBN_PI_BYTE1     8'h11
`define TBN_FWI          4'h6
`define TBN_ADC          2'h0
`define TBN_FO           2'h1
`define TBN_PAR_WUP      3
`define TBN_ATQB_LEN     4'hc
`define TBN_LEN_REQ      4'h3
`define TBN_LEN_SM       4'h1
`define TBN_LEN_ATT      4'h9
`define TBN_CODE_MAX     3'h4
`define TBN_ST_IDLE      3'h0
`define TBN_ST_WAIT      3'h1
`define TBN_ST_READY     3'h2
`define TBN_ST_ACTIVE    3'h3
`define TBN_ST_HALT      3'h4
`define TBN_LFSR_SEED    16'hace1
`endif

//--- src/tbn_buf.v
// Two-entry valid/ready buffer for response bytes
`default_nettype none
module tbn_buf #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         clk_i,
    input  wire         rst_i,
    // Fill side
    input  wire         in_valid_i,
    output wire         in_ready_o,
    input  wire [W-1:0] in_data_i,
    // Drain side
    output wire         out_valid_o,
    input  wire         out_ready_i,
    output wire [W-1:0] out_data_o
);
    reg [W-1:0] mem [0:1];
    reg         wp;
    reg         rp;
    reg [1:0]   cnt;
    wire        push;
    wire        pop;

    assign in_ready_o  = (cnt != 2'h2);
    assign out_valid_o = (cnt != 2'h0);
    assign out_data_o  = mem[rp];
    assign push = in_valid_i & in_ready_o;
    assign pop  = out_valid_o & out_ready_i;

    always @(posedge clk_i) begin
        if (rst_i) begin
            wp  <= 1'b0;
            rp  <= 1'b0;
            cnt <= 2'h0;
        end else begin
            if (push) begin
                mem[wp] <= in_data_i;
                wp      <= ~wp;
            end
            if (pop)
                rp <= ~rp;
            cnt <= cnt + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

//--- sim/tbn_reader_model.sv
// Reader and framer model facing the command handler
`default_nettype none
module tbn_reader_model (
    // Clock
    input  wire logic       clk_i,
    // Request bytes toward the card
    output var  logic       rx_valid_o,
    output var  logic [7:0] rx_data_o,
    output var  logic       rx_sof_o,
    output var  logic       rx_eof_o,
    // Response acceptance
    output var  logic       tx_ready_o,
    input  wire logic       stall_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Frame sender and stalling sink
    // ------------------------------------------------------------
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o  = 8'h00;
        rx_sof_o   = 1'b0;
        rx_eof_o   = 1'b0;
    end
    // Ready toggles every cycle while a stall is requested
    always @(negedge clk_i) begin
        tx_ready_o <= stall_i ? ~tx_ready_o : 1'b1;
    end
    task automatic send(input logic [71:0] f, input int n);
        for (int k = 0; k < n; k++) begin
            @(negedge clk_i);
            rx_valid_o = 1'b1;
            rx_sof_o   = (k == 0);
            rx_data_o  = f[8*k +: 8];
        end
        @(negedge clk_i);
        rx_valid_o = 1'b0;
        rx_sof_o   = 1'b0;
        rx_eof_o   = 1'b1;
        // Released data line shows no stale byte
        rx_data_o  = ~rx_data_o;
        @(negedge clk_i);
        rx_eof_o   = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- sim/tbn_handler_monitor.sv
// Assertion checker for the command handler ports
`default_nettype none
`include "tbn_defs.vh"
module tbn_handler_monitor (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // Response stream
    input wire logic       tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic       tx_last_o,
    input wire logic       tx_ready_i,
    // Status
    input wire logic [2:0] state_o,
    input wire logic [3:0] cid_o,
    input wire logic [3:0] slot_o,
    input wire logic       active_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       acc;
    logic [3:0] cnt;
    assign acc = tx_valid_o && tx_ready_i;
    // Bytes already taken in the current response frame
    always @(posedge clk_i) begin
        if (rst_i)
            cnt <= 4'h0;
        else if (acc)
            cnt <= tx_last_o ? 4'h0 : cnt + 4'h1;
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_enter_ready;
        state_o == `TBN_ST_READY && $past(state_o) != `TBN_ST_READY;
    endsequence
    a_tx_hold: assert property (
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)
        && $stable(tx_last_o)) else $error("response byte dropped");
    a_active_flag: assert property (
        active_o == (state_o == `TBN_ST_ACTIVE)) else $error("active flag");
    a_active_entry: assert property (
        state_o == `TBN_ST_ACTIVE && $past(state_o) != `TBN_ST_ACTIVE
        |-> $past(state_o) == `TBN_ST_READY) else $error("bad active entry");
    a_halt_entry: assert property (
        state_o == `TBN_ST_HALT && $past(state_o) != `TBN_ST_HALT
        |-> $past(state_o) == `TBN_ST_ACTIVE) else $error("bad halt entry");
    a_wait_slot: assert property (
        state_o == `TBN_ST_WAIT |-> slot_o != 4'h0) else $error("slot one waits");
    a_ready_answers: assert property (
        s_enter_ready |-> ##[0:6] tx_valid_o) else $error("no answer");
    a_atqb_first: assert property (
        acc && cnt == 4'h0 && state_o == `TBN_ST_READY
        |-> tx_data_o == `TBN_ATQB_IND) else $error("bad indicator");
    a_atqb_last: assert property (
        acc && tx_last_o && state_o == `TBN_ST_READY |-> cnt == 4'hb
        && tx_data_o == {`TBN_FWI, `TBN_ADC, `TBN_FO}) else $error("bad tail");
    a_attrib_resp: assert property (
        acc && state_o == `TBN_ST_ACTIVE |-> tx_last_o
        && tx_data_o == {4'h0, cid_o}) else $error("bad attrib answer");
endmodule
bind tbn_handler tbn_handler_monitor tbn_handler_monitor_inst (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .tx_valid_o(tx_valid_o),
    .tx_data_o (tx_data_o),
    .tx_last_o (tx_last_o),
    .tx_ready_i(tx_ready_i),
    .state_o   (state_o),
    .cid_o     (cid_o),
    .slot_o    (slot_o),
    .active_o  (active_o)
);
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the command handler
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        stall = 1'b0;
    logic [63:0] uid_i = 64'h8877665544332211;
    logic [31:0] app_data_i = 32'hd4c3b2a1;
    logic [7:0]  afi_i = 8'h35;
    wire         rx_valid, rx_sof, rx_eof, tx_valid, tx_last, tx_ready;
    wire  [7:0]  rx_data, tx_data;
    wire  [2:0]  state;
    wire  [3:0]  cid, slot;
    wire         active;
    logic [8:0]  rq[$];
    int          err_total = 0;
    int          total_checks = 0;
    // ------------------------------------------------------------
    // Design, reader model and response capture
    // ------------------------------------------------------------
    tbn_handler tbn_handler_inst (.clk_i(clk_i), .rst_i(rst_i),
        .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_sof_i(rx_sof),
        .rx_eof_i(rx_eof), .uid_i(uid_i), .app_data_i(app_data_i),
        .afi_i(afi_i), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
        .tx_last_o(tx_last), .tx_ready_i(tx_ready), .state_o(state),
        .cid_o(cid), .slot_o(slot), .active_o(active));
    tbn_reader_model tbn_reader_model_inst (.clk_i(clk_i),
        .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_sof_o(rx_sof),
        .rx_eof_o(rx_eof), .tx_ready_o(tx_ready), .stall_i(stall));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (tx_valid && tx_ready)
            rq.push_back({tx_last, tx_data});
    end
    task automatic complete_run();
        if (err_total == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic req(input logic [71:0] f, input int n, input int nr);
        int w;
        rq.delete();
        tbn_reader_model_inst.send(f, n);
        for (w = 0; w < 60 && rq.size() < nr; w++)
            @(negedge clk_i);
        repeat (nr == 0 ? 40 : 2) @(negedge clk_i);
        check(9'(rq.size()), 9'(nr));
        if (rq.size() < nr)
            complete_run();
    endtask
    task automatic atqb();
        logic [95:0] e;
        e = {8'h61, 8'h11, 8'h77, app_data_i, uid_i[31:0], 8'h50};
        for (int k = 0; k < 12; k++)
            check(rq[k], {k == 11, e[8*k +: 8]});
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
        req({8'h07, 8'h01, 16'h0, uid_i[31:0], 8'h1d}, 9, 0);
        check(state, 9'h0);
        stall = 1'b1;
        req({8'h00, 8'h00, 8'h05}, 3, 12);
        atqb();
        check(state, 9'h2);
        stall = 1'b0;
        req({8'h07, 8'h01, 16'h0, uid_i[31:0], 8'h1d}, 9, 1);
        check(rq[0], 9'h107);
        check(state, 9'h3);
        check(cid, 9'h7);
        check(active, 9'h1);
        req(72'hc2, 1, 1);
        check(rq[0], 9'h100);
        check(state, 9'h4);
        check(active, 9'h0);
        req({8'h00, 8'h00, 8'h05}, 3, 0);
        check(state, 9'h4);
        req({8'h08, 8'h30, 8'h05}, 3, 12);
        atqb();
        check(state, 9'h2);
        req({8'h00, 8'h31, 8'h05}, 3, 0);
        check(state, 9'h0);
        req({8'h05, 8'h35, 8'h05}, 3, 0);
        req({8'h06, 8'h35, 8'h05}, 3, 0);
        check(state, 9'h0);
        for (int i = 0; i < 8; i++) begin
            logic [8:0] lim;
            lim = 9'h1 << (i % 4 + 1);
            rq.delete();
            tbn_reader_model_inst.send({5'h0, 3'(i % 4 + 1), 16'h3505}, 3);
            repeat (40) @(negedge clk_i);
            check(9'({5'h0, slot} < lim), 9'h1);
            if (slot === 4'h0) begin
                check(9'(rq.size()), 9'hc);
                atqb();
            end else begin
                check(state, 9'h1);
                req({slot - 4'h1, 4'h5}, 1, 0);
                req({slot, 4'h5}, 1, 12);
                atqb();
            end
            check(state, 9'h2);
        end
        complete_run();
    end
endmodule
`default_nettype wire
